// [common/chain_sync_defs.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the chain clock/sync block.
// Assumes: The register clock runs with a period of PCLK_NS nanoseconds.
// Notes:   Included by the package, by the clock/sync module and by the testbench.
`ifndef CHAIN_SYNC_DEFS_SVH
`define CHAIN_SYNC_DEFS_SVH

`define NUM_CH         12
`define CNT_W          8

`define OFS_CTRL       12'h000
`define OFS_CHSEL      12'h004
`define OFS_STATUS     12'h008

`define CTRL_INIT_BIT  0
`define CTRL_SYNC_BIT  1
`define CTRL_LVDS_BIT  2
`define CTRL_CLR_BIT   3

`define INIT_RST       1'b1
`define LVDS_RST       1'b0
`define CLR_RST        1'b0
`define CHSEL_RST      12'h000

`define PCLK_NS        50
`define ALIGN_OUT_NS   500
`define ALIGN_OUT_CYC  ((`ALIGN_OUT_NS + `PCLK_NS - 1) / `PCLK_NS)
`define HOLD_NS        1000
`define HOLD_CYC       ((`HOLD_NS + `PCLK_NS - 1) / `PCLK_NS)
`define INT_HALF_CYC   4

`endif

// [common/chain_sync_pkg.sv]
// Purpose: Types shared by the chain clock/sync block and its link receiver.
// Assumes: Constants come from chain_sync_defs.svh.
// Notes:   Holds the state records and the input agreement filter.
`include "chain_sync_defs.svh"

package chain_sync_pkg;

  typedef enum logic [0:0] {ST_IDLE, ST_HOLD} seq_state_t;

  typedef struct packed {
    logic hi;
    logic lo;
  } pin_pair_t;

  typedef struct packed {
    logic             initiator;
    logic             lvds;
    logic             clr_en;
    logic [`NUM_CH-1:0] chsel;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic [2:0]       sy_clk;
    logic             f_clk;
    logic [2:0]       sy_alp;
    logic             f_alp;
    logic [2:0]       sy_tck;
    logic             f_tck;
    logic [2:0]       sy_aln;
    logic             f_aln;
    logic [`CNT_W-1:0] div_cnt;
    logic             int_clk;
    seq_state_t       seq;
    logic [`CNT_W-1:0] hold_cnt;
    logic [`CNT_W-1:0] aout_cnt;
    logic [`CNT_W-1:0] sync_cnt;
    pin_pair_t        clk_out;
    pin_pair_t        aln_out;
    logic [`NUM_CH-1:0] conv_tick;
    logic             conv_hold;
    logic             conv_start;
    logic             buf_clear;
  } chain_state_t;

  typedef struct packed {
    logic [2:0] sy;
    logic       lvl;
    logic       aln_tgl;
    logic       tck_tgl;
  } link_state_t;

  // A level moves only once the second and third stages agree.
  function automatic logic filt(input logic s2, input logic s3, input logic prev);
    filt = (s2 == s3) ? s3 : prev;
  endfunction : filt

endpackage : chain_sync_pkg

// [src/chain_clock_sync.sv]
// Purpose: Clock and alignment distribution for a chain of acquisition boards.
// Assumes: APB master on pclk; chain_clock_in is the target's sample clock.
// Notes:   Differential receivers and drivers sit in the pads; lvds_sel steers them.
`timescale 1ns/10ps
`default_nettype none
`include "chain_sync_defs.svh"

module chain_clock_sync #(
  parameter logic [`CNT_W-1:0] INT_HALF = `INT_HALF_CYC
) (
  // APB slave
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output var  logic [31:0]               prdata,
  output var  logic                      pready,
  output var  logic                      pslverr,
  // Chain link
  input  wire logic                      chain_clock_in,
  input  wire chain_sync_pkg::pin_pair_t chain_align_in,
  output var  chain_sync_pkg::pin_pair_t chain_clock_out,
  output var  chain_sync_pkg::pin_pair_t chain_align_out,
  output var  logic                      lvds_sel,
  // Converter side
  output var  logic [`NUM_CH-1:0]        conv_tick,
  output var  logic                      conv_hold,
  output var  logic                      conv_start,
  output var  logic                      buf_clear
);

  localparam logic [`CNT_W-1:0] HOLD_LAST = `CNT_W'(`HOLD_CYC - 1);
  localparam logic [`CNT_W-1:0] AOUT_LEN  = `CNT_W'(`ALIGN_OUT_CYC);

  chain_sync_pkg::chain_state_t st_r;
  chain_sync_pkg::chain_state_t st_nxt;

  logic       aln_tgl;
  logic       tck_tgl;
  logic       acc;
  logic       wr;
  logic       sw_sync;
  logic       tck_new;
  logic       aln_new;
  logic       ext_tick;
  logic       aln_evt;
  logic       int_tick;
  logic       start;

  // Decodes a word address of the register map.
  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = (a == `OFS_CTRL) || (a == `OFS_CHSEL) || (a == `OFS_STATUS);
  endfunction : reg_hit

  chain_link_rx u_link (
    .link_clk (chain_clock_in),
    .presetn  (presetn),
    .align_in (chain_align_in),
    .aln_tgl  (aln_tgl),
    .tck_tgl  (tck_tgl)
  );

  assign acc      = psel && penable;
  assign wr       = acc && st_r.pready && pwrite && !st_r.pslverr;
  assign sw_sync  = wr && (paddr == `OFS_CTRL) && pwdata[`CTRL_SYNC_BIT];
  assign tck_new  = chain_sync_pkg::filt(st_r.sy_tck[1], st_r.sy_tck[2], st_r.f_tck);
  assign aln_new  = chain_sync_pkg::filt(st_r.sy_aln[1], st_r.sy_aln[2], st_r.f_aln);
  assign ext_tick = tck_new ^ st_r.f_tck;
  assign aln_evt  = (aln_new ^ st_r.f_aln) && !st_r.initiator;
  assign int_tick = (st_r.div_cnt == '0) && !st_r.int_clk;
  assign start    = sw_sync || aln_evt;

  always_comb begin
    st_nxt = st_r;

    // APB: one wait state, then the answer stands for one cycle.
    st_nxt.pready  = acc && !st_r.pready;
    st_nxt.pslverr = acc && !st_r.pready && !reg_hit(paddr);
    if (acc && !st_r.pready) begin
      case (paddr)
        `OFS_CTRL: begin
          st_nxt.prdata = 32'({st_r.clr_en, st_r.lvds, st_r.seq == chain_sync_pkg::ST_HOLD,
                               st_r.initiator});
        end
        `OFS_CHSEL: begin
          st_nxt.prdata = 32'(st_r.chsel);
        end
        `OFS_STATUS: begin
          st_nxt.prdata = {16'h0000, st_r.sync_cnt, 5'h00, st_r.f_alp, st_r.f_clk,
                           st_r.seq == chain_sync_pkg::ST_HOLD};
        end
        default: begin
          st_nxt.prdata = 32'h0000_0000;
        end
      endcase
    end
    if (wr && (paddr == `OFS_CTRL)) begin
      st_nxt.initiator = pwdata[`CTRL_INIT_BIT];
      st_nxt.lvds      = pwdata[`CTRL_LVDS_BIT];
      st_nxt.clr_en    = pwdata[`CTRL_CLR_BIT];
    end
    if (wr && (paddr == `OFS_CHSEL)) begin
      st_nxt.chsel = pwdata[`NUM_CH-1:0];
    end

    // Pin and cross-domain inputs pass three stages.
    // The link clock is too fast to filter on pclk, so it is rebuilt from its synchronised edge toggles.
    st_nxt.sy_clk = {st_r.sy_clk[1:0], ext_tick};
    st_nxt.f_clk  = ext_tick || st_r.sy_clk[0];
    st_nxt.sy_alp = {st_r.sy_alp[1:0], chain_align_in.hi};
    st_nxt.f_alp  = chain_sync_pkg::filt(st_r.sy_alp[1], st_r.sy_alp[2], st_r.f_alp);
    st_nxt.sy_tck = {st_r.sy_tck[1:0], tck_tgl};
    st_nxt.f_tck  = tck_new;
    st_nxt.sy_aln = {st_r.sy_aln[1:0], aln_tgl};
    st_nxt.f_aln  = aln_new;

    // Internal sample clock.
    if (st_r.div_cnt == '0) begin
      st_nxt.div_cnt = INT_HALF - `CNT_W'(1);
      st_nxt.int_clk = !st_r.int_clk;
    end else begin
      st_nxt.div_cnt = st_r.div_cnt - `CNT_W'(1);
    end

    // Alignment sequence.
    st_nxt.conv_start = 1'b0;
    st_nxt.buf_clear  = aln_evt && st_r.clr_en;
    if (start) begin
      st_nxt.seq       = chain_sync_pkg::ST_HOLD;
      st_nxt.hold_cnt  = HOLD_LAST;
      st_nxt.conv_hold = 1'b1;
      st_nxt.sync_cnt  = st_r.sync_cnt + `CNT_W'(1);
    end else begin
      case (st_r.seq)
        chain_sync_pkg::ST_HOLD: begin
          if (st_r.hold_cnt == '0) begin
            st_nxt.seq        = chain_sync_pkg::ST_IDLE;
            st_nxt.conv_hold  = 1'b0;
            st_nxt.conv_start = 1'b1;
          end else begin
            st_nxt.hold_cnt = st_r.hold_cnt - `CNT_W'(1);
          end
        end
        default: begin
          st_nxt.seq = chain_sync_pkg::ST_IDLE;
        end
      endcase
    end

    // Outgoing alignment pulse of the initiator.
    if (sw_sync && st_r.initiator) begin
      st_nxt.aout_cnt = AOUT_LEN;
    end else if (st_r.aout_cnt != '0) begin
      st_nxt.aout_cnt = st_r.aout_cnt - `CNT_W'(1);
    end

    // Chain outputs.
    st_nxt.clk_out.hi = st_r.initiator ? st_r.int_clk : st_r.f_clk;
    st_nxt.aln_out.hi = st_r.initiator ? (st_r.aout_cnt != '0) : st_r.f_alp;
    st_nxt.clk_out.lo = st_r.lvds && !st_nxt.clk_out.hi;
    st_nxt.aln_out.lo = st_r.lvds && !st_nxt.aln_out.hi;

    // Converter timing per channel.
    for (int i = 0; i < `NUM_CH; i++) begin
      st_nxt.conv_tick[i] = !st_r.conv_hold &&
                            ((!st_r.initiator && st_r.chsel[i]) ? ext_tick : int_tick);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r           <= '0;
      st_r.initiator <= `INIT_RST;
      st_r.lvds      <= `LVDS_RST;
      st_r.clr_en    <= `CLR_RST;
      st_r.chsel     <= `CHSEL_RST;
      st_r.seq       <= chain_sync_pkg::ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata          = st_r.prdata;
  assign pready          = st_r.pready;
  assign pslverr         = st_r.pslverr;
  assign chain_clock_out = st_r.clk_out;
  assign chain_align_out = st_r.aln_out;
  assign lvds_sel        = st_r.lvds;
  assign conv_tick       = st_r.conv_tick;
  assign conv_hold       = st_r.conv_hold;
  assign conv_start      = st_r.conv_start;
  assign buf_clear       = st_r.buf_clear;

  // Checks.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_clk_init;
    st_r.initiator && $past(st_r.initiator) |-> ##1 chain_clock_out.hi == $past(st_r.int_clk);
  endproperty
  a_clk_init: assert property (p_clk_init) else $error("Initiator clock output wrong.");

  property p_clk_target;
    !st_r.initiator && !$past(st_r.initiator) && $rose(st_r.f_clk) |=> chain_clock_out.hi;
  endproperty
  a_clk_target: assert property (p_clk_target) else $error("Target clock not repeated.");

  property p_aln_init;
    sw_sync && st_r.initiator |-> ##2 chain_align_out.hi [*8];
  endproperty
  a_aln_init: assert property (p_aln_init) else $error("Initiator sync pulse missing.");

  property p_lvds_pair;
    $past(st_r.lvds) |-> (chain_clock_out.lo == !chain_clock_out.hi) &&
                         (chain_align_out.lo == !chain_align_out.hi);
  endproperty
  a_lvds_pair: assert property (p_lvds_pair) else $error("Differential outputs not paired.");

  property p_ttl_lo;
    !$past(st_r.lvds) |-> !chain_clock_out.lo && !chain_align_out.lo;
  endproperty
  a_ttl_lo: assert property (p_ttl_lo) else $error("Low-side output active in single-ended mode.");

  property p_unsel_int;
    |(conv_tick & ~$past(st_r.chsel)) |-> $past(int_tick);
  endproperty
  a_unsel_int: assert property (p_unsel_int) else $error("Unselected channel off internal clock.");

  property p_sel_ext;
    !$past(st_r.initiator) && |(conv_tick & $past(st_r.chsel)) |-> $past(ext_tick);
  endproperty
  a_sel_ext: assert property (p_sel_ext) else $error("Selected channel off external clock.");

  property p_ext_hold;
    aln_evt |=> conv_hold [*8];
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("External sync did not hold converters.");

  property p_sw_hold;
    sw_sync |=> conv_hold [*8];
  endproperty
  a_sw_hold: assert property (p_sw_hold) else $error("Software sync did not start sequence.");

  property p_clear;
    aln_evt && st_r.clr_en |=> buf_clear;
  endproperty
  a_clear: assert property (p_clear) else $error("Buffer clear missing.");

  property p_release;
    $fell(conv_hold) |-> conv_start && (conv_tick == '0);
  endproperty
  a_release: assert property (p_release) else $error("Release without common start.");

  property p_once;
    aln_evt |=> !aln_evt;
  endproperty
  a_once: assert property (p_once) else $error("Sync edge counted twice.");

  property p_repeat_aln;
    !st_r.initiator && !$past(st_r.initiator) && $rose(st_r.f_alp) |=> chain_align_out.hi;
  endproperty
  a_repeat_aln: assert property (p_repeat_aln) else $error("Sync not repeated.");

  property p_clk_copy;
    !st_r.initiator |=> chain_clock_out.hi == $past(st_r.f_clk);
  endproperty
  a_clk_copy: assert property (p_clk_copy) else $error("Target clock output not a copy.");

  property p_aln_copy;
    !st_r.initiator |=> chain_align_out.hi == $past(st_r.f_alp);
  endproperty
  a_aln_copy: assert property (p_aln_copy) else $error("Target sync output not a copy.");

  property p_sel_all;
    !st_r.initiator && !st_r.conv_hold && ext_tick |=> (conv_tick & $past(st_r.chsel)) == $past(st_r.chsel);
  endproperty
  a_sel_all: assert property (p_sel_all) else $error("Selected channel missed an external tick.");

  property p_tick_gap;
    ext_tick |=> !ext_tick ##1 !ext_tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("External clock ticks too close.");

  property p_count;
    start |=> st_r.sync_cnt == $past(st_r.sync_cnt) + 8'h01;
  endproperty
  a_count: assert property (p_count) else $error("Sequence count not advanced.");

  property p_restart;
    start |=> conv_hold && (st_r.hold_cnt == HOLD_LAST);
  endproperty
  a_restart: assert property (p_restart) else $error("Sequence did not restart its count.");

  property p_clear_src;
    buf_clear |-> $past(aln_evt) && $past(st_r.clr_en);
  endproperty
  a_clear_src: assert property (p_clear_src) else $error("Buffer clear without enabled sync.");

  property p_hold_quiet;
    $past(conv_hold) |-> conv_tick == '0;
  endproperty
  a_hold_quiet: assert property (p_hold_quiet) else $error("Conversion tick during hold.");

  property p_start_once;
    conv_start |=> !conv_start;
  endproperty
  a_start_once: assert property (p_start_once) else $error("Common start longer than one cycle.");

  property p_sw_busy;
    sw_sync |=> st_r.seq == chain_sync_pkg::ST_HOLD;
  endproperty
  a_sw_busy: assert property (p_sw_busy) else $error("Software sync did not show busy.");

  property p_self_clear;
    $fell(conv_hold) |-> st_r.seq == chain_sync_pkg::ST_IDLE;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("Sync busy did not clear.");

  c_sw_sync:  cover property (sw_sync && st_r.initiator);
  c_ext_sync: cover property (aln_evt);
  c_clear:    cover property (buf_clear);
  c_start:    cover property (conv_start);
  c_tgt_tick: cover property (!st_r.initiator && ext_tick);

endmodule : chain_clock_sync

`default_nettype wire

// [src/chain_link_rx.sv]
// Purpose: Link-side receiver clocked by the incoming chain clock.
// Assumes: The chain clock may stop between frames; alignment edges are only seen while it runs.
// Notes:   Events leave this domain as toggles only.
`timescale 1ns/10ps
`default_nettype none

module chain_link_rx (
  // Link clock and reset
  input  wire logic                    link_clk,
  input  wire logic                    presetn,
  // Incoming alignment pins
  input  wire chain_sync_pkg::pin_pair_t align_in,
  // Events toward the register clock
  output var  logic                    aln_tgl,
  output var  logic                    tck_tgl
);

  chain_sync_pkg::link_state_t st_r;
  chain_sync_pkg::link_state_t st_nxt;

  always_comb begin
    st_nxt     = st_r;
    // Only the high-side pin carries the level; the low side is ignored.
    st_nxt.sy  = {st_r.sy[1:0], align_in.hi};
    st_nxt.lvl = chain_sync_pkg::filt(st_r.sy[1], st_r.sy[2], st_r.lvl);
    if (st_nxt.lvl && !st_r.lvl) begin
      st_nxt.aln_tgl = !st_r.aln_tgl;
    end
    // Each rising sample clock edge is passed on as a toggle.
    st_nxt.tck_tgl = !st_r.tck_tgl;
  end

  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign aln_tgl = st_r.aln_tgl;
  assign tck_tgl = st_r.tck_tgl;

endmodule : chain_link_rx

`default_nettype wire

// [tb/chain_far_end.sv]
// Purpose: Far-end board that feeds the chain clock and alignment pins.
// Assumes: Its sample clock runs freely with a 160 ns period.
// Notes:   An alignment pulse stays high for five link clocks after fire rises.
`timescale 1ns/10ps
`default_nettype none

module chain_far_end (
  // Control from the bench
  input  wire logic                      fire,
  input  wire logic                      lvds,
  // Chain pins toward the board
  output var  logic                      link_clk,
  output var  chain_sync_pkg::pin_pair_t align_pins
);
  logic aln_v = 1'b0;

  initial begin
    link_clk = 1'b0;
    #37;
    forever begin
      #80 link_clk = ~link_clk;
    end
  end

  always @(posedge fire) begin
    @(posedge link_clk);
    aln_v <= 1'b1;
    repeat (5) @(posedge link_clk);
    aln_v <= 1'b0;
  end

  // The low side floats in single-ended mode and carries the complement otherwise.
  assign align_pins = {aln_v, lvds ? ~aln_v : 1'bz};
endmodule : chain_far_end

`default_nettype wire

// [tb/testbench.sv]
// Purpose: Self-checking bench for the chain clock and alignment block.
// Assumes: APB master on pclk; the far end runs its link clock freely.
// Notes:   Counts that cross clocks allow a small slack.
`timescale 1ns/10ps
`default_nettype none
`include "chain_sync_defs.svh"

module testbench;
  logic                      pclk, presetn, psel, penable, pwrite, fire, e, prev_co;
  logic [11:0]               paddr;
  logic [31:0]               pwdata, prdata, q;
  logic [7:0]                s;
  logic                      pready, pslverr, link_clk, lvds_sel, conv_hold, conv_start, buf_clear;
  chain_sync_pkg::pin_pair_t align_in, clk_out, aln_out;
  logic [`NUM_CH-1:0]        conv_tick;
  int                        failures, checks_done, co_tg, lo_bad, st_n, bc_n, t0, t1, ao_w;

  chain_clock_sync #(.INT_HALF(8'h04)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chain_clock_in(link_clk), .chain_align_in(align_in), .chain_clock_out(clk_out),
    .chain_align_out(aln_out), .lvds_sel(lvds_sel), .conv_tick(conv_tick), .conv_hold(conv_hold),
    .conv_start(conv_start), .buf_clear(buf_clear));
  chain_far_end far (.fire(fire), .lvds(lvds_sel), .link_clk(link_clk), .align_pins(align_in));

  initial begin
    pclk = 1'b0;
    forever begin
      #25 pclk = ~pclk;
    end
  end

  always @(negedge pclk) begin
    prev_co <= clk_out.hi;
    co_tg += (clk_out.hi !== prev_co);
    lo_bad += (clk_out.lo !== (lvds_sel & ~clk_out.hi));
    lo_bad += (aln_out.lo !== (lvds_sel & ~aln_out.hi));
    st_n += (conv_start === 1'b1);
    bc_n += (buf_clear === 1'b1);
    t0 += (conv_tick[0] === 1'b1);
    t1 += (conv_tick[1] === 1'b1);
    ao_w += (aln_out.hi === 1'b1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic clr;
    @(posedge pclk);
    {co_tg, lo_bad, st_n, bc_n, t0, t1, ao_w} = '0;
  endtask : clr

  task automatic wait_hold;
    int n;
    n = 0;
    while (conv_hold !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_hold

  task automatic test_done;
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    #300000;
    failures++;
    test_done();
  end

  initial begin
    {failures, checks_done} = '0;
    {psel, penable, pwrite, fire} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(q, 32'h0000_0001);
    apb(1'b0, `OFS_CHSEL, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    $display("test reset_values done");
    clr();
    repeat (40) @(posedge pclk);
    chk(co_tg, 32'd10);
    chk(lo_bad, 32'd0);
    apb(1'b0, `OFS_STATUS, 32'h0);
    s = q[15:8];
    clr();
    apb(1'b1, `OFS_CTRL, 32'h0000_0003);
    wait_hold();
    chk(conv_hold, 1'b1);
    repeat (40) @(posedge pclk);
    chk(ao_w, `ALIGN_OUT_CYC);
    chk(st_n, 32'd1);
    chk(bc_n, 32'd0);
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(q, 32'h0000_0001);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(q[15:8], s + 8'h01);
    $display("test initiator_sync done");
    apb(1'b1, `OFS_CTRL, 32'h0000_0005);
    clr();
    repeat (40) @(posedge pclk);
    chk(lvds_sel, 1'b1);
    chk(lo_bad, 32'd0);
    chk(co_tg, 32'd10);
    $display("test differential done");
    apb(1'b1, `OFS_CHSEL, 32'h0000_0005);
    apb(1'b1, `OFS_CTRL, 32'h0000_0008);
    apb(1'b0, `OFS_CHSEL, 32'h0);
    chk(q, 32'h0000_0005);
    repeat (20) @(posedge pclk);
    clr();
    repeat (320) @(posedge pclk);
    chk(co_tg >= 198 && co_tg <= 202, 1'b1);
    chk(t0 >= 98 && t0 <= 102, 1'b1);
    chk(t1 >= 38 && t1 <= 42, 1'b1);
    chk(lo_bad, 32'd0);
    apb(1'b0, `OFS_STATUS, 32'h0);
    s = q[15:8];
    clr();
    fire <= 1'b1;
    wait_hold();
    chk(conv_hold, 1'b1);
    repeat (60) @(posedge pclk);
    fire <= 1'b0;
    chk(st_n, 32'd1);
    chk(bc_n, 32'd1);
    chk(ao_w >= 14 && ao_w <= 18, 1'b1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(q[15:8], s + 8'h01);
    apb(1'b1, `OFS_CTRL, 32'h0);
    clr();
    fire <= 1'b1;
    wait_hold();
    repeat (60) @(posedge pclk);
    fire <= 1'b0;
    chk(st_n, 32'd1);
    chk(bc_n, 32'd0);
    $display("test target_repeat done");
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(q, 32'h0000_0001);
    apb(1'b0, `OFS_CHSEL, 32'h0);
    chk(q, 32'h0);
    $display("test mid_reset done");
    test_done();
  end
endmodule : testbench

`default_nettype wire
